// >>> acr_params.svh
// timing counts, offsets, field positions and reset values of the register bank
// assumes inclusion by bare name from the block's package and modules
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_PTR_RESULT   4'h0
`define ACR_PTR_CONFIG   4'h2
`define ACR_CFG_RESET    12'h00C
`define ACR_CFG_CH_LO    4
`define ACR_CFG_FILT     3
`define ACR_CFG_ALEN     2
`define ACR_CFG_BUSY     1
`define ACR_CFG_POL      0
`define ACR_FILT_TAPS    3
`define ACR_LOW2_MASK    12'hFFC
`endif

// >>> acr_pkg.sv
// types shared by the register bank and its line filter
// assumes acr_params.svh is on the include path
`include "acr_params.svh"
package acr_pkg;
    typedef struct packed {
        logic [7:0] chanSel;
        logic       filtEn;
        logic       alertEn;
        logic       busyNotAlert;
        logic       polarity;
    } acr_cfg_type;

    typedef struct packed {
        logic        violation;
        logic [2:0]  chanTag;
        logic [11:0] value;
    } acr_result_type;

    typedef struct packed {
        logic        valid;
        logic        first;
        logic [7:0]  data;
    } acr_wbyte_type;

    typedef struct packed {
        logic        done;
        logic        limitViol;
        logic [11:0] data;
    } acr_conv_type;

    typedef struct packed {
        logic [1:0]                    syncA;
        logic [1:0]                    syncB;
        logic [1:0][`ACR_FILT_TAPS-1:0] taps;
        logic [1:0]                    lineOut;
    } acr_filt_type;

    typedef struct packed {
        logic [3:0]     pointer;
        acr_cfg_type    cfg;
        acr_result_type result;
        logic           wrPhase;
        logic [7:0]     cfgHigh;
        logic           rdPhase;
        logic [7:0]     rdLow;
        logic [7:0]     rdByte;
        logic           rdValid;
        logic           alertActive;
        logic [2:0]     curChan;
        logic           statusClear;
        logic           pinOut;
        logic           pinOen;
    } acr_state_type;
endpackage

// >>> acr_glitch_filter.sv
// bus line glitch filter for the serial data and clock inputs
// assumes raw pin levels from outside the clock domain; bypass keeps the synchroniser and the output register
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_glitch_filter (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       filtEn,
    input  wire logic [1:0] lineIn,
    output logic      [1:0] lineOut
);
    import acr_pkg::*;
    acr_filt_type st_ff;
    acr_filt_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.syncA = lineIn;
        nxt_st.syncB = st_ff.syncA;
        for (int i = 0; i < 2; i++) begin
            nxt_st.taps[i] = {st_ff.taps[i][`ACR_FILT_TAPS-2:0], st_ff.syncB[i]};
            if (!filtEn) begin
                nxt_st.lineOut[i] = st_ff.syncB[i];
            end else if (&st_ff.taps[i]) begin
                nxt_st.lineOut[i] = 1'b1;
            end else if (~|st_ff.taps[i]) begin
                nxt_st.lineOut[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lineOut = st_ff.lineOut;
endmodule

// >>> acr_regs.sv
// configuration and conversion result registers behind the address pointer
// assumes a serial byte engine feeding write bytes and read requests, and a converter core
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_regs #(
    parameter bit TEN_BIT_VARIANT = 1'b0
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic [1:0]            busLineIn,
    output logic      [1:0]            busLineFilt,
    input  wire logic                  txnStart,
    input  wire acr_pkg::acr_wbyte_type wrByte,
    input  wire logic                  rdByteReq,
    output logic      [7:0]            rdByte,
    output logic                       rdByteValid,
    input  wire acr_pkg::acr_conv_type conv,
    input  wire logic                  adcBusy,
    output logic      [2:0]            convChannel,
    output logic      [7:0]            channelSelect,
    output logic                       alarmStatusClear,
    output logic                       alertPinOut,
    output logic                       alertPinOen
);
    import acr_pkg::*;
    acr_state_type st_ff;
    acr_state_type nxt_st;
    acr_cfg_type   newCfg;
    logic          cfgCommit;
    logic          resetAlarm;
    logic          pinActive;
    logic          pinLevel;
    logic [11:0]   convValue;

    // lowest selected channel above cur, else wrap to lowest selected
    function automatic logic [2:0] nextChan(input logic [7:0] sel, input logic [2:0] cur);
        logic [2:0] lo;
        logic [2:0] up;
        logic       found;
        lo = cur;
        up = cur;
        found = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (sel[i]) begin
                lo = 3'(i);
            end
            if (sel[i] && (3'(i) > cur)) begin
                up = 3'(i);
                found = 1'b1;
            end
        end
        return found ? up : lo;
    endfunction

    acr_glitch_filter u_filter (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .filtEn  (st_ff.cfg.filtEn),
        .lineIn  (busLineIn),
        .lineOut (busLineFilt)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdValid = 1'b0;
        nxt_st.statusClear = 1'b0;
        cfgCommit = 1'b0;
        newCfg = acr_cfg_type'({st_ff.cfgHigh[3:0], wrByte.data});
        convValue = TEN_BIT_VARIANT ? (conv.data & `ACR_LOW2_MASK) : conv.data;

        if (txnStart) begin
            nxt_st.wrPhase = 1'b0;
            nxt_st.rdPhase = 1'b0;
        end

        if (wrByte.valid && wrByte.first) begin
            nxt_st.pointer = wrByte.data[3:0];
            nxt_st.wrPhase = 1'b0;
        end else if (wrByte.valid && (st_ff.pointer == `ACR_PTR_CONFIG)) begin
            if (!st_ff.wrPhase) begin
                nxt_st.cfgHigh = wrByte.data;
                nxt_st.wrPhase = 1'b1;
            end else begin
                cfgCommit = 1'b1;
                nxt_st.wrPhase = 1'b0;
            end
        end

        resetAlarm = cfgCommit && newCfg.alertEn && newCfg.busyNotAlert;
        if (cfgCommit) begin
            nxt_st.cfg = newCfg;
            nxt_st.curChan = nextChan(newCfg.chanSel, 3'h7);
        end

        if (resetAlarm) begin
            nxt_st.alertActive = 1'b0;
            nxt_st.result.violation = 1'b0;
            nxt_st.statusClear = 1'b1;
        end

        if (conv.done) begin
            nxt_st.result.value = convValue;
            nxt_st.result.chanTag = st_ff.curChan;
            nxt_st.result.violation = conv.limitViol;
            if (conv.limitViol && st_ff.cfg.alertEn) begin
                nxt_st.alertActive = 1'b1;
            end
            if (!cfgCommit) begin
                nxt_st.curChan = nextChan(st_ff.cfg.chanSel, st_ff.curChan);
            end
        end

        if (rdByteReq) begin
            nxt_st.rdValid = 1'b1;
            nxt_st.rdPhase = !st_ff.rdPhase;
            if (st_ff.rdPhase) begin
                nxt_st.rdByte = st_ff.rdLow;
            end else if (st_ff.pointer == `ACR_PTR_RESULT) begin
                nxt_st.rdByte = st_ff.result[15:8];
                nxt_st.rdLow = st_ff.result[7:0];
            end else if (st_ff.pointer == `ACR_PTR_CONFIG) begin
                nxt_st.rdByte = {4'h0, st_ff.cfg[11:8]};
                nxt_st.rdLow = st_ff.cfg[7:0];
            end else begin
                nxt_st.rdByte = 8'h00;
                nxt_st.rdLow = 8'h00;
            end
        end

        unique case ({st_ff.cfg.alertEn, st_ff.cfg.busyNotAlert})
            2'b01: begin
                pinActive = adcBusy;
            end
            2'b10: begin
                pinActive = st_ff.alertActive;
            end
            2'b00, 2'b11: begin
                pinActive = 1'b0;
            end
        endcase
        pinLevel = st_ff.cfg.polarity ? pinActive : !pinActive;
        nxt_st.pinOut = 1'b0;
        nxt_st.pinOen = pinLevel;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.cfg <= acr_cfg_type'(`ACR_CFG_RESET);
            st_ff.pinOen <= 1'b0;
            st_ff.pointer <= `ACR_PTR_RESULT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdByte = st_ff.rdByte;
    assign rdByteValid = st_ff.rdValid;
    assign convChannel = st_ff.curChan;
    assign channelSelect = st_ff.cfg.chanSel;
    assign alarmStatusClear = st_ff.statusClear;
    assign alertPinOut = st_ff.pinOut;
    assign alertPinOen = st_ff.pinOen;
endmodule

// >>> acr_regs_assertions.sv
// port checker for the register bank
// assumes binding onto every acr_regs instance
`timescale 1ns/100ps
module acr_regs_chk #(
    parameter bit TEN_BIT_VARIANT = 1'b0
) (
    input wire logic                   sys_clk,
    input wire logic                   nrst,
    input wire logic [1:0]             busLineIn,
    input wire logic [1:0]             busLineFilt,
    input wire logic                   txnStart,
    input wire acr_pkg::acr_wbyte_type wrByte,
    input wire logic                   rdByteReq,
    input wire logic [7:0]             rdByte,
    input wire logic                   rdByteValid,
    input wire acr_pkg::acr_conv_type  conv,
    input wire logic                   adcBusy,
    input wire logic [2:0]             convChannel,
    input wire logic [7:0]             channelSelect,
    input wire logic                   alarmStatusClear,
    input wire logic                   alertPinOut,
    input wire logic                   alertPinOen
);
    import acr_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    function automatic logic [2:0] nextCh(logic [7:0] s, logic [2:0] c);
        nextCh = c;
        for (int k = 8; k >= 1; k--)
            if (s[3'(c + k)]) nextCh = 3'(c + k);
    endfunction
    AST_RD_ANSWER: assert property (rdByteReq |=> rdByteValid)
        else $error("read byte not answered");
    AST_RD_CAUSE: assert property (rdByteValid |-> $past(rdByteReq))
        else $error("read byte without request");
    AST_RD_HOLD: assert property ($changed(rdByte) |-> $past(rdByteReq))
        else $error("read data changed without request");
    AST_SEL_CHAN: assert property (channelSelect != 8'h00 |-> channelSelect[convChannel])
        else $error("channel not selected");
    AST_SEQ_UP: assert property (conv.done && !wrByte.valid && channelSelect != 8'h00
        |=> convChannel == nextCh($past(channelSelect), $past(convChannel)))
        else $error("sequence step wrong");
    AST_SEL_WRITE: assert property ($changed(channelSelect) |-> $past(wrByte.valid))
        else $error("select changed without write");
    AST_CLR_CAUSE: assert property (alarmStatusClear
        |-> $past(wrByte.valid && wrByte.data[2:1] == 2'b11))
        else $error("clear without reset write");
    AST_CLR_PULSE: assert property (alarmStatusClear |=> !alarmStatusClear)
        else $error("clear longer than one cycle");
endmodule
bind acr_regs acr_regs_chk #(.TEN_BIT_VARIANT(TEN_BIT_VARIANT)) i_chk (.sys_clk, .nrst,
    .busLineIn, .busLineFilt, .txnStart, .wrByte, .rdByteReq, .rdByte, .rdByteValid, .conv,
    .adcBusy, .convChannel, .channelSelect, .alarmStatusClear, .alertPinOut, .alertPinOen);

// >>> acr_host_model.sv
// host model: pointer and data bytes, read requests, transaction starts
// assumes a byte engine in front of the register bank
`timescale 1ns/100ps
module acr_host_model (
    input  wire logic             sys_clk,
    input  wire logic [7:0]       rdByte,
    output acr_pkg::acr_wbyte_type wrByte,
    output logic                  txnStart,
    output logic                  rdByteReq
);
    import acr_pkg::*;
    int gap = 0;
    initial begin
        wrByte = '0;
        txnStart = 1'b0;
        rdByteReq = 1'b0;
    end
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic start;
        step();
        txnStart = 1'b1;
        step();
        txnStart = 1'b0;
    endtask
    task automatic put(input logic f, input logic [7:0] d);
        repeat (gap) step();
        step();
        wrByte = '{1'b1, f, d};
        step();
        wrByte.valid = 1'b0;
    endtask
    task automatic wr(input logic [3:0] p, input logic [15:0] w);
        start();
        put(1'b1, {4'h0, p});
        put(1'b0, w[15:8]);
        put(1'b0, w[7:0]);
    endtask
    task automatic rd(input logic [3:0] p, input bit setPtr, output logic [15:0] w);
        if (setPtr) begin
            start();
            put(1'b1, {4'h0, p});
        end
        start();
        for (int b = 0; b < 2; b++) begin
            step();
            rdByteReq = 1'b1;
            step();
            rdByteReq = 1'b0;
            w = {w[7:0], rdByte};
        end
    endtask
endmodule

// >>> acr_regs_tb_top.sv
// self-checking bench for the register bank
// assumes the host model stands in for the serial byte engine
`timescale 1ns/100ps
module acr_regs_tb_top;
    import acr_pkg::*;
    logic          sys_clk, nrst, txnStart, rdByteReq, rdByteValid, adcBusy, seen;
    logic          alarmStatusClear, alertPinOut, alertPinOen;
    logic [1:0]    busLineIn, busLineFilt;
    logic [2:0]    convChannel;
    logic [7:0]    rdByte, channelSelect, rdByte10;
    logic [15:0]   w;
    acr_wbyte_type wrByte;
    acr_conv_type  conv;
    int            n_mismatch, n_checks, nClr;
    int            tags[5] = '{0, 2, 5, 7, 0};
    acr_regs i_dut (.sys_clk, .nrst, .busLineIn, .busLineFilt, .txnStart, .wrByte, .rdByteReq,
        .rdByte, .rdByteValid, .conv, .adcBusy, .convChannel, .channelSelect, .alarmStatusClear,
        .alertPinOut, .alertPinOen);
    acr_regs #(.TEN_BIT_VARIANT(1'b1)) i_dut10 (.sys_clk, .nrst, .busLineIn, .busLineFilt(),
        .txnStart, .wrByte, .rdByteReq, .rdByte(rdByte10), .rdByteValid(), .conv, .adcBusy,
        .convChannel(), .channelSelect(), .alarmStatusClear(), .alertPinOut(), .alertPinOen());
    acr_host_model i_host (.sys_clk, .rdByte, .wrByte, .txnStart, .rdByteReq);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cvt(input logic v, input logic [11:0] d);
        tick(1);
        conv = '{1'b1, v, d};
        tick(1);
        conv.done = 1'b0;
    endtask
    task automatic glitch;
        busLineIn[0] = 1'b0;
        tick(1);
        busLineIn[0] = 1'b1;
        seen = 1'b0;
        repeat (8) begin
            tick(1);
            seen |= !busLineFilt[0];
        end
    endtask
    always @(posedge sys_clk) if (alarmStatusClear === 1'b1) nClr++;
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        tick(20000);
        n_mismatch++;
        complete_run();
    end
    initial begin
        {nrst, adcBusy, conv, busLineIn} = {2'b00, 14'h0000, 2'b11};
        tick(5);
        nrst = 1'b1;
        tick(2);
        chk(busLineFilt, 2'b11);
        chk(alertPinOen, 1'b1);
        chk(alertPinOut, 1'b0);
        i_host.rd(4'h0, 0, w); chk(w, 16'h0000);
        i_host.rd(4'h2, 1, w); chk(w, 16'h000C);
        glitch(); chk(seen, 1'b0);
        $display("reset test done");
        i_host.gap = 2;
        i_host.wr(4'h2, 16'h0A5C); tick(1); chk(channelSelect, 8'hA5);
        for (int i = 0; i < 5; i++) begin
            chk(convChannel, 16'(tags[i]));
            cvt(1'b0, 12'h5A0 + 12'(i));
            i_host.rd(4'h0, 1, w); chk(w, {1'b0, 3'(tags[i]), 12'h5A0 + 12'(i)});
            chk(rdByte10, 16'((12'h5A0 + 12'(i)) & 12'h0FC));
        end
        $display("sequence test done");
        i_host.gap = 0;
        cvt(1'b1, 12'hFFF); tick(1); chk(alertPinOen, 1'b0);
        i_host.rd(4'h0, 1, w); chk(w, 16'hAFFF);
        i_host.wr(4'h2, 16'h0A5D); tick(2); chk(alertPinOen, 1'b1);
        i_host.wr(4'h2, 16'h0A5E); tick(2); chk(alertPinOen, 1'b1);
        chk(nClr, 16'h0001);
        i_host.wr(4'h2, 16'h0A5C); tick(2); chk(alertPinOen, 1'b1);
        i_host.rd(4'h0, 1, w); chk(w, 16'h2FFF);
        i_host.wr(4'h0, 16'h1234); i_host.rd(4'h0, 1, w); chk(w, 16'h2FFF);
        $display("alarm test done");
        i_host.wr(4'h2, 16'h0A5A); adcBusy = 1'b1; tick(2); chk(alertPinOen, 1'b0);
        adcBusy = 1'b0; tick(2); chk(alertPinOen, 1'b1);
        i_host.wr(4'h2, 16'h0A58); adcBusy = 1'b1; tick(2); chk(alertPinOen, 1'b1);
        adcBusy = 1'b0;
        cvt(1'b1, 12'h123); tick(1); chk(alertPinOen, 1'b1);
        $display("pin role test done");
        i_host.wr(4'h2, 16'h0A50); tick(2); glitch(); chk(seen, 1'b1);
        $display("filter test done");
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(2);
        chk(busLineFilt, 2'b11);
        chk(alertPinOen, 1'b1);
        i_host.rd(4'h0, 0, w); chk(w, 16'h0000);
        i_host.rd(4'h2, 1, w); chk(w, 16'h000C);
        $display("second reset test done");
        complete_run();
    end
endmodule
